// >>> pit_cfg.svh
// Constants of the predictive interval timer: timing, fields, offsets
`ifndef PIT_CFG_SVH
`define PIT_CFG_SVH

// Timing
`define PIT_CLK_MHZ      250
`define PIT_TICK_US      1
`define PIT_TICK_CYC     (`PIT_TICK_US * `PIT_CLK_MHZ)
`define PIT_EARLY_US     56
`define PIT_CNT_MAX      16'hffff

// Device identity on the I/O bus
`define PIT_DEV_CODE     6'h2a
`define PIT_MASK_BIT     4

// Control bits of location C
`define PIT_C_FREEZE     0
`define PIT_C_RUN        1
`define PIT_C_LD_OVF     2
`define PIT_C_LD_PROG    3
`define PIT_C_LD_INTG    4
`define PIT_C_ZERO       5
`define PIT_C_SAMPLE     6
`define PIT_C_DRIVE      7

// Reset values
`define PIT_CNT_RST      16'h0000
`define PIT_CTL_RST      8'h00

// Host register offsets
`define PIT_OFS_CMD      8'h00
`define PIT_OFS_WDATA    8'h04
`define PIT_OFS_RDATA    8'h08
`define PIT_OFS_STAT     8'h0c

// Command register fields
`define PIT_CMD_OP_LSB   0
`define PIT_CMD_CTL_LSB  3
`define PIT_CMD_RST_BIT  5
`define PIT_CMD_MSK_BIT  6
`define PIT_CMD_DEV_LSB  8

// Bus responses
`define PIT_RESP_OKAY    2'h0
`define PIT_RESP_SLVERR  2'h2

`endif

// >>> pit_pkg.sv
// Types shared by both ends of the interval timer link
package pit_pkg;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_OUT_A = 3'b001,
      OP_OUT_B = 3'b010,
      OP_OUT_C = 3'b011,
      OP_IN_A = 3'b100,
      OP_IN_B = 3'b101,
      OP_IN_C = 3'b110
   } pit_op_e;

   typedef enum logic [1:0] {
      CTL_NONE = 2'b00,
      CTL_START = 2'b01,
      CTL_CLEAR = 2'b10,
      CTL_PULSE = 2'b11
   } pit_ctl_e;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_ISSUE = 2'b01,
      H_CAPT = 2'b10
   } pit_hstate_e;

   typedef struct packed {
      logic [15:0] count;
      logic [15:0] preset;
      logic [15:0] sample;
      logic [7:0]  ctl;
      logic        busy;
      logic        done;
      logic        int_dis;
      logic [15:0] rd_data;
      logic        rd_oe_n;
      logic        warn;
      logic [2:0]  sync;
      logic        intg_lvl;
   } pit_dev_s;

   typedef struct packed {
      pit_hstate_e state;
      logic [15:0] cmd;
      logic [15:0] wdata;
      logic [15:0] rdata;
      logic        aw_have;
      logic [7:0]  awaddr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] r_data;
      logic [1:0]  rresp;
      pit_op_e     op;
      pit_ctl_e    ctl;
      logic        io_reset;
      logic        mask_out;
      logic [5:0]  dev_code;
      logic        h_oe_n;
   } pit_host_s;

endpackage

// >>> pit_io_if.sv
// Programmed I/O bus between the host controller and the interval timer
`timescale 1ns/1ps
`default_nettype none
interface pit_io_if;
   logic [5:0]  dev_code;
   logic        output_to_a;
   logic        output_to_b;
   logic        output_to_c;
   logic        input_from_a;
   logic        input_from_b;
   logic        input_from_c;
   logic        start;
   logic        clear;
   logic        pulse;
   logic        bus_wide_io_reset;
   logic        mask_out;
   logic [15:0] h_data;
   logic        h_oe_n;
   logic [15:0] d_data;
   logic        d_oe_n;
   logic        busy;
   logic        done;
   logic        intr;
   wire  [15:0] data;

   // Shared data lines: whichever end enables its drivers sets the level, the host if both do
   assign data = !h_oe_n ? h_data : (!d_oe_n ? d_data : 16'h0000);

   modport device (
      input  dev_code, output_to_a, output_to_b, output_to_c,
      input  input_from_a, input_from_b, input_from_c,
      input  start, clear, pulse, bus_wide_io_reset, mask_out, data,
      output d_data, d_oe_n, busy, done, intr
   );
   modport host (
      output dev_code, output_to_a, output_to_b, output_to_c,
      output input_from_a, input_from_b, input_from_c,
      output start, clear, pulse, bus_wide_io_reset, mask_out,
      output h_data, h_oe_n,
      input  data, busy, done, intr
   );
endinterface
`default_nettype wire

// >>> pit_tick_div.sv
// Divider producing a one-cycle enable every DIV clock cycles
`timescale 1ns/1ps
`default_nettype none
module pit_tick_div #(
   parameter int unsigned DIV = 16
) (
   input  wire logic CLOCK_I,
   input  wire logic RST_N_I,
   output logic      TICK_O
);
   typedef struct packed {
      logic [15:0] cnt;
   } pit_div_s;

   pit_div_s s_r;
   pit_div_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (s_r.cnt == 16'(DIV - 1)) begin
         s_nxt.cnt = 16'h0000;
      end else begin
         s_nxt.cnt = s_r.cnt + 16'h0001;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign TICK_O = (s_r.cnt == 16'(DIV - 1));
endmodule
`default_nettype wire

// >>> pit_interval_timer_dev.sv
// Interval timer device end: counter, latch, control and busy/done logic
`include "pit_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pit_interval_timer_dev
   import pit_pkg::*;
#(
   parameter logic [5:0] DEV_CODE = `PIT_DEV_CODE,
   parameter int unsigned MASK_BIT = `PIT_MASK_BIT
) (
   // Clock and reset
   input  wire logic  CLOCK_I,
   input  wire logic  RST_N_I,
   // Receiver interrogation pulse, asynchronous
   input  wire logic  INTG_I,
   // Early warning to the controlled target generators
   output logic [2:0] WARN_O,
   output logic       EARLY_O,
   // Programmed I/O bus
   pit_io_if.device   io
);
   pit_dev_s    s_r;
   pit_dev_s    s_nxt;
   logic        tick;
   logic        sel;
   logic        fire;
   logic [7:0]  pbits;
   logic        intg_rise;
   logic        ovf;

   pit_tick_div #(
      .DIV (`PIT_TICK_CYC)
   ) u_tick (
      .CLOCK_I (CLOCK_I),
      .RST_N_I (RST_N_I),
      .TICK_O  (tick)
   );

   always_comb begin
      s_nxt = s_r;
      s_nxt.warn = 1'b0;
      s_nxt.rd_oe_n = 1'b1;
      ovf = 1'b0;

      // Interrogation input: three flops, change counts once last two agree
      s_nxt.sync = {s_r.sync[1:0], INTG_I};
      intg_rise = 1'b0;
      if (s_r.sync[1] == s_r.sync[2]) begin
         s_nxt.intg_lvl = s_r.sync[2];
         intg_rise = s_r.sync[2] & ~s_r.intg_lvl;
      end

      sel = (io.dev_code == DEV_CODE);

      // Output transfers to locations A and C; B holds nothing
      if (sel && io.output_to_a) begin
         s_nxt.preset = io.data;
      end
      if (sel && io.output_to_c) begin
         s_nxt.ctl = io.data[7:0];
      end

      // General pulse fires the pulse-type control bits
      pbits = (sel && io.output_to_c) ? io.data[7:0] : s_r.ctl;
      fire = sel && io.pulse;

      // Counting on each microsecond tick
      if (tick && s_r.ctl[`PIT_C_RUN]) begin
         if (s_r.count == `PIT_CNT_MAX) begin
            ovf = 1'b1;
            s_nxt.warn = 1'b1;
            if (s_r.ctl[`PIT_C_LD_OVF]) begin
               s_nxt.count = s_r.preset;
            end else if (s_r.ctl[`PIT_C_FREEZE]) begin
               s_nxt.ctl[`PIT_C_RUN] = 1'b0;
               s_nxt.ctl[`PIT_C_FREEZE] = 1'b0;
            end else begin
               s_nxt.count = `PIT_CNT_RST;
            end
         end else begin
            s_nxt.count = s_r.count + 16'h0001;
         end
      end

      // Loads of the preset, zeroing and sampling of the count
      if (intg_rise && s_r.ctl[`PIT_C_LD_INTG]) begin
         s_nxt.count = s_r.preset;
      end
      if (fire && pbits[`PIT_C_LD_PROG]) begin
         s_nxt.count = s_r.preset;
      end
      if (fire && pbits[`PIT_C_ZERO]) begin
         s_nxt.count = `PIT_CNT_RST;
      end
      if (fire && pbits[`PIT_C_SAMPLE]) begin
         s_nxt.sample = s_r.count;
      end

      // Status flip-flops
      if (sel && io.start) begin
         s_nxt.busy = 1'b1;
         s_nxt.done = 1'b0;
      end
      if (sel && io.clear) begin
         s_nxt.busy = 1'b0;
         s_nxt.done = 1'b0;
      end
      if (io.bus_wide_io_reset) begin
         s_nxt.busy = 1'b0;
         s_nxt.done = 1'b0;
         s_nxt.int_dis = 1'b0;
      end
      if (io.mask_out) begin
         s_nxt.int_dis = io.data[MASK_BIT];
      end
      // Completion wins over a clear in the same cycle
      if (ovf) begin
         s_nxt.busy = 1'b0;
         s_nxt.done = 1'b1;
      end

      // Input transfers; drivers for location A open only when the drive level is set
      if (sel && io.input_from_a && s_r.ctl[`PIT_C_DRIVE]) begin
         s_nxt.rd_data = s_r.sample;
         s_nxt.rd_oe_n = 1'b0;
      end
      if (sel && io.input_from_b) begin
         s_nxt.rd_data = 16'h0000;
         s_nxt.rd_oe_n = 1'b0;
      end
      if (sel && io.input_from_c) begin
         s_nxt.rd_data = {8'h00, s_r.ctl};
         s_nxt.rd_oe_n = 1'b0;
      end
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_r <= '0;
         s_r.rd_oe_n <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Interrupt request follows done and disable without delay
   assign io.intr = s_r.done & ~s_r.int_dis;
   assign io.busy = s_r.busy;
   assign io.done = s_r.done & ~s_r.busy;
   assign io.d_data = s_r.rd_data;
   assign io.d_oe_n = s_r.rd_oe_n;
   assign WARN_O = {3{s_r.warn}};
   assign EARLY_O = s_r.warn;
endmodule
`default_nettype wire

// >>> pit_host_ctrl.sv
// Host end: AXI4-Lite registers that issue programmed I/O commands
`include "pit_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pit_host_ctrl
   import pit_pkg::*;
(
   // Clock and reset
   input  wire logic        CLOCK_I,
   input  wire logic        RST_N_I,
   // AXI4-Lite write
   input  wire logic        S_AXI_AWVALID_I,
   output logic             S_AXI_AWREADY_O,
   input  wire logic [7:0]  S_AXI_AWADDR_I,
   input  wire logic        S_AXI_WVALID_I,
   output logic             S_AXI_WREADY_O,
   input  wire logic [31:0] S_AXI_WDATA_I,
   input  wire logic [3:0]  S_AXI_WSTRB_I,
   output logic             S_AXI_BVALID_O,
   input  wire logic        S_AXI_BREADY_I,
   output logic [1:0]       S_AXI_BRESP_O,
   // AXI4-Lite read
   input  wire logic        S_AXI_ARVALID_I,
   output logic             S_AXI_ARREADY_O,
   input  wire logic [7:0]  S_AXI_ARADDR_I,
   output logic             S_AXI_RVALID_O,
   input  wire logic        S_AXI_RREADY_I,
   output logic [31:0]      S_AXI_RDATA_O,
   output logic [1:0]       S_AXI_RRESP_O,
   // Programmed I/O bus
   pit_io_if.host           io
);
   pit_host_s s_r;
   pit_host_s s_nxt;

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] st);
      merge = {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `PIT_OFS_CMD) || (a == `PIT_OFS_WDATA) ||
               (a == `PIT_OFS_RDATA) || (a == `PIT_OFS_STAT);
   endfunction

   always_comb begin
      s_nxt = s_r;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.awaddr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = S_AXI_WDATA_I;
         s_nxt.w_strb = S_AXI_WSTRB_I;
      end
      if (s_r.bvalid && S_AXI_BREADY_I) begin
         s_nxt.bvalid = 1'b0;
      end
      // Writes complete only while no bus command is in flight
      if (s_r.aw_have && s_r.w_have && s_r.state == H_IDLE) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = mapped(s_r.awaddr) ? `PIT_RESP_OKAY : `PIT_RESP_SLVERR;
         if (s_r.awaddr == `PIT_OFS_WDATA) begin
            s_nxt.wdata = merge(s_r.wdata, s_r.w_data, s_r.w_strb);
         end
         if (s_r.awaddr == `PIT_OFS_CMD) begin
            s_nxt.cmd = merge(s_r.cmd, s_r.w_data, s_r.w_strb);
            s_nxt.state = H_ISSUE;
         end
      end
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = mapped(S_AXI_ARADDR_I) ? `PIT_RESP_OKAY : `PIT_RESP_SLVERR;
         unique case (S_AXI_ARADDR_I)
            `PIT_OFS_CMD: s_nxt.r_data = {16'h0000, s_r.cmd};
            `PIT_OFS_WDATA: s_nxt.r_data = {16'h0000, s_r.wdata};
            `PIT_OFS_RDATA: s_nxt.r_data = {16'h0000, s_r.rdata};
            `PIT_OFS_STAT: s_nxt.r_data = {28'h0000000, s_r.state != H_IDLE,
                                           io.intr, io.done, io.busy};
            default: s_nxt.r_data = 32'h00000000;
         endcase
      end else if (s_r.rvalid && S_AXI_RREADY_I) begin
         s_nxt.rvalid = 1'b0;
      end

      // Bus command sequencing: strobes stand for exactly one cycle
      s_nxt.op = OP_NONE;
      s_nxt.ctl = CTL_NONE;
      s_nxt.io_reset = 1'b0;
      s_nxt.mask_out = 1'b0;
      s_nxt.h_oe_n = 1'b1;
      unique case (s_r.state)
         H_IDLE: begin
            if (s_nxt.state == H_ISSUE) begin
               s_nxt.op = pit_op_e'(s_nxt.cmd[`PIT_CMD_OP_LSB +: 3]);
               s_nxt.ctl = pit_ctl_e'(s_nxt.cmd[`PIT_CMD_CTL_LSB +: 2]);
               s_nxt.io_reset = s_nxt.cmd[`PIT_CMD_RST_BIT];
               s_nxt.mask_out = s_nxt.cmd[`PIT_CMD_MSK_BIT];
               s_nxt.dev_code = s_nxt.cmd[`PIT_CMD_DEV_LSB +: 6];
               s_nxt.h_oe_n = ~(s_nxt.cmd[`PIT_CMD_MSK_BIT] |
                                (s_nxt.cmd[`PIT_CMD_OP_LSB +: 3] inside {3'b001, 3'b010, 3'b011}));
            end
         end
         H_ISSUE: begin
            s_nxt.state = s_r.op inside {OP_IN_A, OP_IN_B, OP_IN_C} ? H_CAPT : H_IDLE;
         end
         H_CAPT: begin
            s_nxt.rdata = io.data;
            s_nxt.state = H_IDLE;
         end
         default: s_nxt.state = H_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_r <= '0;
         s_r.h_oe_n <= 1'b1;
         // Bus-wide reset pulse in the first cycle after power-up
         s_r.io_reset <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign S_AXI_AWREADY_O = ~s_r.aw_have & ~s_r.bvalid;
   assign S_AXI_WREADY_O = ~s_r.w_have & ~s_r.bvalid;
   assign S_AXI_BVALID_O = s_r.bvalid;
   assign S_AXI_BRESP_O = s_r.bresp;
   assign S_AXI_ARREADY_O = ~s_r.rvalid;
   assign S_AXI_RVALID_O = s_r.rvalid;
   assign S_AXI_RDATA_O = s_r.r_data;
   assign S_AXI_RRESP_O = s_r.rresp;
   assign io.dev_code = s_r.dev_code;
   assign io.output_to_a = (s_r.op == OP_OUT_A);
   assign io.output_to_b = (s_r.op == OP_OUT_B);
   assign io.output_to_c = (s_r.op == OP_OUT_C);
   assign io.input_from_a = (s_r.op == OP_IN_A);
   assign io.input_from_b = (s_r.op == OP_IN_B);
   assign io.input_from_c = (s_r.op == OP_IN_C);
   assign io.start = (s_r.ctl == CTL_START);
   assign io.clear = (s_r.ctl == CTL_CLEAR);
   assign io.pulse = (s_r.ctl == CTL_PULSE);
   assign io.bus_wide_io_reset = s_r.io_reset;
   assign io.mask_out = s_r.mask_out;
   assign io.h_data = s_r.wdata;
   assign io.h_oe_n = s_r.h_oe_n;
endmodule
`default_nettype wire

// >>> pit_io_chk.sv
// Concurrent checks on the programmed I/O bus and early-warning outputs
`include "pit_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pit_io_chk #(
   parameter logic [5:0]  DEV_CODE = `PIT_DEV_CODE,
   parameter int unsigned MASK_BIT = `PIT_MASK_BIT
) (
   // Clock and reset
   input wire logic        CLOCK_I,
   input wire logic        RST_N_I,
   // Host strobes
   input wire logic [5:0]  dev_code,
   input wire logic        input_from_a,
   input wire logic        input_from_b,
   input wire logic        input_from_c,
   input wire logic        start,
   input wire logic        clear,
   input wire logic        bus_wide_io_reset,
   input wire logic        mask_out,
   input wire logic        h_oe_n,
   // Device status and data
   input wire logic        d_oe_n,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        intr,
   input wire logic [15:0] data,
   // Early warning
   input wire logic [2:0]  WARN_O,
   input wire logic        EARLY_O
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_start;
      start && dev_code == DEV_CODE && !clear && !bus_wide_io_reset;
   endsequence
   sequence s_clear;
      clear && dev_code == DEV_CODE && !start;
   endsequence
   sequence s_idle;
      !busy && !done;
   endsequence

   busy_done_excl_a: assert property (busy |-> !done)
      else $error("done seen while busy");
   intr_needs_done_a: assert property (intr |-> done)
      else $error("interrupt without done");
   start_sets_busy_a: assert property (s_start |=> (busy && !done) || EARLY_O)
      else $error("start did not set busy");
   clear_idles_a: assert property (s_clear |=> s_idle or EARLY_O)
      else $error("clear left busy or done");
   io_reset_idles_a: assert property (bus_wide_io_reset |=> s_idle or EARLY_O)
      else $error("bus reset left busy or done");
   foreign_ignored_a: assert property (start && dev_code != DEV_CODE && !busy |=> !busy)
      else $error("start to another device acted");
   mask_blocks_a: assert property (mask_out && data[MASK_BIT] |=> !intr)
      else $error("mask-out did not block interrupt");
   unmask_intr_a: assert property (mask_out && !data[MASK_BIT] && done && !clear && !start
      && !bus_wide_io_reset |=> intr)
      else $error("unmask with done gave no interrupt");
   warn_all_three_a: assert property (WARN_O != 3'b000 |-> WARN_O == 3'b111 && EARLY_O)
      else $error("warning not sent to all generators");
   warn_pulse_a: assert property (EARLY_O |=> !EARLY_O [*8])
      else $error("early pulse longer than one cycle");
   warn_done_a: assert property (EARLY_O |-> ##[0:1] (done && !busy))
      else $error("overflow did not complete operation");
   drive_after_in_a: assert property (!d_oe_n |-> $past(input_from_a) || $past(input_from_b)
      || $past(input_from_c))
      else $error("device drove data unasked");
   bus_no_fight_a: assert property (!(!h_oe_n && !d_oe_n))
      else $error("both ends drive data lines");
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench: host controller and timer device joined by the I/O bus
`include "pit_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pit_pkg::*;
   localparam logic [5:0] DEV = `PIT_DEV_CODE;
   localparam logic [7:0] CMD = `PIT_OFS_CMD;
   localparam logic [7:0] STA = `PIT_OFS_STAT;
   localparam logic [7:0] RDA = `PIT_OFS_RDATA;
   localparam logic [1:0] OK  = `PIT_RESP_OKAY;
   localparam logic [1:0] ERR = `PIT_RESP_SLVERR;

   logic        clk, rst_n, intg, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, early;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [2:0]  warn;
   logic [34:0] rq[$];
   logic [1:0]  bq[$];
   logic [15:0] p;
   int          fails, comparisons, warn_cnt, i, seed, interrogation_repeat_interval;

   pit_io_if io();
   pit_host_ctrl pit_host_ctrl_i (
      .CLOCK_I(clk), .RST_N_I(rst_n),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_BRESP_O(bresp), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .io(io));
   pit_interval_timer_dev #(.DEV_CODE(DEV), .MASK_BIT(`PIT_MASK_BIT)) pit_interval_timer_dev_i (
      .CLOCK_I(clk), .RST_N_I(rst_n), .INTG_I(intg), .WARN_O(warn), .EARLY_O(early), .io(io));
   pit_io_chk #(.DEV_CODE(DEV), .MASK_BIT(`PIT_MASK_BIT)) pit_io_chk_i (
      .CLOCK_I(clk), .RST_N_I(rst_n), .dev_code(io.dev_code), .input_from_a(io.input_from_a),
      .input_from_b(io.input_from_b), .input_from_c(io.input_from_c), .start(io.start),
      .clear(io.clear), .bus_wide_io_reset(io.bus_wide_io_reset), .mask_out(io.mask_out),
      .h_oe_n(io.h_oe_n), .d_oe_n(io.d_oe_n), .busy(io.busy), .done(io.done),
      .intr(io.intr), .data(io.data), .WARN_O(warn), .EARLY_O(early));

   always #2 clk = ~clk;

   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task close_out;
      $display("Mismatches %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Write: address and data offered together, each released when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      bit aw_ok, w_ok;
      bq.push_back(er);
      aw_ok = 0;
      w_ok = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      rq.push_back({1'b1, er, ed});
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
   endtask

   function automatic logic [15:0] cw(input pit_op_e op, input pit_ctl_e ctl,
                                      input logic rst, input logic msk, input logic [5:0] dev);
      logic [15:0] w;
      w = 16'h0000;
      w[`PIT_CMD_OP_LSB +: 3] = op;
      w[`PIT_CMD_CTL_LSB +: 2] = ctl;
      w[`PIT_CMD_RST_BIT] = rst;
      w[`PIT_CMD_MSK_BIT] = msk;
      w[`PIT_CMD_DEV_LSB +: 6] = dev;
      return w;
   endfunction

   // Data word, command, then an empty command that waits for the first to finish
   task automatic io_cmd(input logic [15:0] wd, input logic [15:0] c);
      axi_wr(`PIT_OFS_WDATA, {16'h0000, wd}, OK);
      axi_wr(CMD, {16'h0000, c}, OK);
      axi_wr(CMD, 32'h0000_0000, OK);
   endtask

   task automatic stat(input logic [3:0] e);
      axi_rd(STA, {28'h0000000, e}, OK);
   endtask

   // Result monitor: oldest note against each answer
   always @(posedge clk) begin
      logic [34:0] n;
      if (rvalid === 1'b1 && rready) begin
         n = rq.pop_front();
         check({rresp, rdata}, n[33:0]);
      end
      if (bvalid === 1'b1 && bready) begin
         check({32'h0, bresp}, {32'h0, bq.pop_front()});
      end
      if (warn !== 3'b000) begin
         warn_cnt <= warn_cnt + 1;
      end
   end

   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      close_out;
   end

   initial begin
      clk = 0;
      rst_n = 0;
      intg = 0;
      awvalid = 0;
      wvalid = 0;
      arvalid = 0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'h3;
      bready = 1;
      rready = 1;
      fails = 0;
      comparisons = 0;
      warn_cnt = 0;
      seed = $urandom(60907);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      stat(4'h0);
      axi_rd(8'h10, 32'h0, ERR);
      axi_wr(8'h14, 32'h1, ERR);
      io_cmd(16'h0000, cw(OP_NONE, CTL_START, 1'b0, 1'b0, DEV ^ 6'h3f));
      stat(4'h0);
      io_cmd(16'h0000, cw(OP_NONE, CTL_START, 1'b0, 1'b0, DEV));
      stat(4'h1);
      io_cmd(16'h0000, cw(OP_NONE, CTL_NONE, 1'b1, 1'b0, 6'h00));
      stat(4'h0);
      for (i = 0; i < 3; i++) begin
         p = 16'($urandom);
         io_cmd(p, cw(OP_OUT_A, CTL_NONE, 1'b0, 1'b0, DEV));
         io_cmd(16'h0008, cw(OP_OUT_C, CTL_PULSE, 1'b0, 1'b0, DEV));
         io_cmd(16'h00c0, cw(OP_OUT_C, CTL_PULSE, 1'b0, 1'b0, DEV));
         io_cmd(16'h0000, cw(OP_IN_A, CTL_NONE, 1'b0, 1'b0, DEV));
         axi_rd(RDA, {16'h0000, p}, OK);
      end
      io_cmd(16'h0000, cw(OP_IN_B, CTL_NONE, 1'b0, 1'b0, DEV));
      axi_rd(RDA, 32'h0, OK);
      io_cmd(16'h0020, cw(OP_OUT_C, CTL_PULSE, 1'b0, 1'b0, DEV));
      io_cmd(16'h00c0, cw(OP_OUT_C, CTL_PULSE, 1'b0, 1'b0, DEV));
      io_cmd(16'h0000, cw(OP_IN_A, CTL_NONE, 1'b0, 1'b0, DEV));
      axi_rd(RDA, 32'h0, OK);
      // Predictive run: short random interval, preset loaded by an interrogation
      interrogation_repeat_interval = 58 + int'($urandom % 4);
      p = 16'(65535 - interrogation_repeat_interval + `PIT_EARLY_US);
      io_cmd(p, cw(OP_OUT_A, CTL_NONE, 1'b0, 1'b0, DEV));
      io_cmd(16'h0013, cw(OP_OUT_C, CTL_NONE, 1'b0, 1'b0, DEV));
      io_cmd(16'h0000, cw(OP_NONE, CTL_START, 1'b0, 1'b0, DEV));
      intg <= 1'b1;
      repeat (8) @(posedge clk);
      intg <= 1'b0;
      for (i = 0; i < 3000 && warn_cnt == 0; i++) @(posedge clk);
      // Warning lands one clock cycle wide, within one tick period after the expected tick count
      check(34'((i + 8 >= (interrogation_repeat_interval - 56) * `PIT_TICK_CYC) &&
                (i + 8 <= (interrogation_repeat_interval - 55) * `PIT_TICK_CYC + 10)), 34'd1);
      repeat (4) @(posedge clk);
      check(34'(warn_cnt), 34'd1);
      // Overflow cleared run and freeze, and the count stays at the top
      io_cmd(16'h0000, cw(OP_IN_C, CTL_NONE, 1'b0, 1'b0, DEV));
      axi_rd(RDA, 32'h0000_0010, OK);
      io_cmd(16'h00c0, cw(OP_OUT_C, CTL_PULSE, 1'b0, 1'b0, DEV));
      io_cmd(16'h0000, cw(OP_IN_A, CTL_NONE, 1'b0, 1'b0, DEV));
      axi_rd(RDA, 32'h0000_ffff, OK);
      stat(4'h6);
      io_cmd(16'h0010, cw(OP_NONE, CTL_NONE, 1'b0, 1'b1, 6'h00));
      stat(4'h2);
      io_cmd(16'h0000, cw(OP_NONE, CTL_NONE, 1'b0, 1'b1, 6'h00));
      stat(4'h6);
      io_cmd(16'h0000, cw(OP_NONE, CTL_CLEAR, 1'b0, 1'b0, DEV));
      stat(4'h0);
      repeat (4) @(posedge clk);
      close_out;
   end
endmodule
`default_nettype wire
